// [host_spi_defines.vh]
// constants shared by the host-port select logic and the spi slave
// assumes a 20 MHz system clock; included by bare name
`ifndef HOST_SPI_DEFINES_VH
`define HOST_SPI_DEFINES_VH

// system clock period
`define CLK_PERIOD_NS 50
// settle time after cold reset before the select straps are trusted
`define SELECT_SETTLE_NS 200
// settle time in clocks, rounded up
`define SELECT_SETTLE_CYCLES ((`SELECT_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// highest serial bit rate of the spi port
`define SPI_MAX_KBPS 10000

// detected host interface codes
`define IFTYPE_UART 2'h0
`define IFTYPE_SPI 2'h1
`define IFTYPE_I2C 2'h2
`define IFTYPE_I2CL 2'h3

// select strap patterns {hi, lo}
`define STRAP_UART 2'h0
`define STRAP_SPI 2'h2
`define STRAP_I2C 2'h1
`define STRAP_I2CL 2'h3

// command byte layout
`define CMD_DIR_BIT 0
`define CMD_ADDR_MSB 7
`define CMD_ADDR_LSB 1
`define CMD_DIR_READ 1'h1

// register address of the data fifo
`define FIFO_REG_ADDR 7'h05

// data fifo shape
`define FIFO_WIDTH 8
`define FIFO_DEPTH 32
`define FIFO_ADDR_BITS 5

`endif

// [bit_sync.v]
// two-stage synchroniser for a group of independent level inputs
// assumes each bit is a slow level or edge-sampled pin, not a bus word
`default_nettype none

module bit_sync #(
	parameter WIDTH = 1
) (
	input wire clock,
	input wire rst,
	input wire [WIDTH-1:0] asyncIn,
	output reg [WIDTH-1:0] syncOut
);

	reg [WIDTH-1:0] stage1_reg; // first stage, read only by the second

	// two flops per bit, nothing taps the first stage
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			stage1_reg <= {WIDTH{1'b0}};
			syncOut <= {WIDTH{1'b0}};
		end else begin
			stage1_reg <= asyncIn;
			syncOut <= stage1_reg;
		end
	end

endmodule // bit_sync

`default_nettype wire

// [sync_fifo.v]
// single-clock fifo with registered output stage
// assumes the writer honours inReady and the reader honours outValid
`default_nettype none

module sync_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	input wire clock,
	input wire rst,
	input wire inValid,
	input wire [WIDTH-1:0] inData,
	output reg inReady,
	output reg outValid,
	output reg [WIDTH-1:0] outData,
	input wire outReady
);

	reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage array
	reg [AW-1:0] wrPtr_reg; // write index
	reg [AW-1:0] rdPtr_reg; // read index
	reg [AW:0] count_reg; // words held in the array
	reg [AW:0] count_next;
	reg [AW:0] held_reg; // words in the array plus the output stage
	reg [AW:0] held_next;
	wire doPush; // accepted write
	wire doPop; // array word moves to output stage
	wire doTake; // output word taken by the reader

	assign doPush = inValid & inReady;
	assign doPop = (count_reg != {(AW+1){1'b0}}) & (~outValid | outReady);
	assign doTake = outValid & outReady;

	// occupancy after this cycle
	always @* begin
		count_next = count_reg;
		held_next = held_reg;
		if (doPush & ~doPop) begin
			count_next = count_reg + 1'b1;
		end else if (~doPush & doPop) begin
			count_next = count_reg - 1'b1;
		end
		// the output stage counts too, else the fifo takes one word past its depth
		if (doPush & ~doTake) begin
			held_next = held_reg + 1'b1;
		end else if (~doPush & doTake) begin
			held_next = held_reg - 1'b1;
		end
	end

	// array write, no reset needed on data
	always @(posedge clock) begin
		if (doPush) begin
			mem[wrPtr_reg] <= inData;
		end
	end

	// pointers, count, ready and output stage
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			wrPtr_reg <= {AW{1'b0}};
			rdPtr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
			held_reg <= {(AW+1){1'b0}};
			inReady <= 1'b1;
			outValid <= 1'b0;
			outData <= {WIDTH{1'b0}};
		end else begin
			count_reg <= count_next;
			held_reg <= held_next;
			// full is exact: ready drops once depth words are held, output stage included
			inReady <= (held_next != DEPTH[AW:0]);
			if (doPush) begin
				wrPtr_reg <= wrPtr_reg + 1'b1;
			end
			if (doPop) begin
				outData <= mem[rdPtr_reg];
				outValid <= 1'b1;
				rdPtr_reg <= rdPtr_reg + 1'b1;
			end else if (outReady) begin
				outValid <= 1'b0;
			end
		end
	end

endmodule // sync_fifo

`default_nettype wire

// [host_if_select_spi_slave.v]
// host port front end: strap-based interface detection and spi slave
// assumes pins and straps are asynchronous; register side runs on clock
// Overview of operation
// - redetect host port on reset or resume
// - sample select straps after cold reset settles
// - straps decode UART, SPI, I2C, I2C-L
// - slave only, never drives the serial clock
// - serial rate up to ten megabits; the edge finder here manages about clock / 8
// - select high holds port state in reset
// - bytes travel most significant bit first
// - sample MOSI on rising clock edges
// - update MISO on falling clock edges
// - first byte is command, LSB gives direction
// - command address is seven bits wide
// - read data lags command by one byte
// - write: one command, many data bytes
// - write address increments per data byte
// - no increment at the fifo address
`include "host_spi_defines.vh"
`default_nettype none

module host_if_select_spi_slave (
	input wire clock,
	input wire rst,
	// host pins: 0 data in, 1 serial clock, 3 select (low active)
	input wire host_pin_0,
	input wire host_pin_1,
	input wire host_pin_3,
	// data out pin as output and enable
	output reg host_pin_2_out,
	output reg host_pin_2_oe,
	// interface select straps
	input wire host_port_select_lo,
	input wire host_port_select_hi,
	// pulse on leaving power down
	input wire powerDownResume,
	// detection result
	output reg [1:0] hostIfType,
	output reg spiSelected,
	output reg detectDone,
	// register write port
	output reg regWrStrobe,
	output reg [6:0] regWrAddr,
	output reg [7:0] regWrData,
	// register read port, data due one cycle after the strobe
	output reg regRdStrobe,
	output reg [6:0] regRdAddr,
	input wire [7:0] regRdData,
	// fifo drain side
	output wire fifoOutValid,
	output wire [7:0] fifoOutData,
	input wire fifoOutReady,
	// fifo fill state and overflow
	output wire fifoInReady,
	output reg fifoOverflow,
	input wire overflowClear
);

	// detection states
	localparam [2:0] DET_SETTLE = 3'b001;
	localparam [2:0] DET_LATCH = 3'b010;
	localparam [2:0] DET_HOLD = 3'b100;

	// byte phase states
	localparam [2:0] PH_CMD = 3'b001;
	localparam [2:0] PH_READ = 3'b010;
	localparam [2:0] PH_WRITE = 3'b100;

	// settle count worked out at full width, then cut to the counter
	localparam [31:0] SETTLE_FULL = `SELECT_SETTLE_CYCLES - 1;
	localparam [3:0] SETTLE_LAST = SETTLE_FULL[3:0];

	wire [4:0] pinSync; // synchronised pins and straps
	wire mosiSync; // data in
	wire sckSync; // serial clock
	wire nssSync; // select, high means idle
	wire selLoSync; // strap low bit
	wire selHiSync; // strap high bit

	reg [2:0] detState_reg; // detection state
	reg [3:0] settleCnt_reg; // settle counter

	reg sckPrev_reg; // last serial clock level
	wire sckRise; // rising edge seen
	wire sckFall; // falling edge seen
	wire portIdle; // port held in reset

	reg [2:0] phase_reg; // byte phase
	reg [2:0] bitCnt_reg; // bits of current byte
	reg [7:0] rxShift_reg; // incoming bits
	wire [7:0] rxByte; // byte completed on this edge
	reg [6:0] addr_reg; // write address
	reg [7:0] txShift_reg; // outgoing bits of current byte
	reg [7:0] txNext_reg; // byte for the next slot
	reg rdLoad_reg; // read data arrives this cycle

	reg pushValid_reg; // fifo write request
	reg [7:0] pushData_reg; // fifo write data
	reg pushDrop_reg; // byte lost to a full fifo

	bit_sync #(
		.WIDTH(5)
	) u_pin_sync (
		.clock(clock),
		.rst(rst),
		.asyncIn({host_port_select_hi, host_port_select_lo, host_pin_3, host_pin_1, host_pin_0}),
		.syncOut(pinSync)
	);

	assign mosiSync = pinSync[0];
	assign sckSync = pinSync[1];
	assign nssSync = pinSync[2];
	assign selLoSync = pinSync[3];
	assign selHiSync = pinSync[4];

	sync_fifo #(
		.WIDTH(`FIFO_WIDTH),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_ADDR_BITS)
	) u_data_fifo (
		.clock(clock),
		.rst(rst),
		.inValid(pushValid_reg),
		.inData(pushData_reg),
		.inReady(fifoInReady),
		.outValid(fifoOutValid),
		.outData(fifoOutData),
		.outReady(fifoOutReady)
	);

	// interface detection: settle, latch straps once, then hold
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			detState_reg <= DET_SETTLE;
			settleCnt_reg <= 4'h0;
			hostIfType <= `IFTYPE_UART;
			spiSelected <= 1'b0;
			detectDone <= 1'b0;
		end else begin
			case (detState_reg)
				DET_SETTLE: begin
					// straps only trusted after the cold phase ends
					if (settleCnt_reg == SETTLE_LAST) begin
						detState_reg <= DET_LATCH;
					end else begin
						settleCnt_reg <= settleCnt_reg + 1'b1;
					end
				end
				DET_LATCH: begin
					// one look at the straps; later changes are not seen until a resume
					detState_reg <= DET_HOLD;
					detectDone <= 1'b1;
					case ({selHiSync, selLoSync})
						`STRAP_SPI: begin
							hostIfType <= `IFTYPE_SPI;
							spiSelected <= 1'b1;
						end
						`STRAP_I2C: begin
							hostIfType <= `IFTYPE_I2C;
							spiSelected <= 1'b0;
						end
						`STRAP_I2CL: begin
							hostIfType <= `IFTYPE_I2CL;
							spiSelected <= 1'b0;
						end
						default: begin
							hostIfType <= `IFTYPE_UART;
							spiSelected <= 1'b0;
						end
					endcase
				end
				DET_HOLD: begin
					// strap changes ignored here; only a resume reopens detection
					if (powerDownResume) begin
						detState_reg <= DET_SETTLE;
						settleCnt_reg <= 4'h0;
						spiSelected <= 1'b0;
						detectDone <= 1'b0;
					end
				end
				default: begin
					detState_reg <= DET_SETTLE;
					settleCnt_reg <= 4'h0;
				end
			endcase
		end
	end

	// serial clock edge finder; clock pin is only ever an input
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			sckPrev_reg <= 1'b0;
		end else begin
			sckPrev_reg <= sckSync;
		end
	end

	// oversampling limits the usable serial rate to about clock / 8
	assign sckRise = sckSync & ~sckPrev_reg;
	assign sckFall = ~sckSync & sckPrev_reg;

	// port disabled unless spi strapped and select low
	// only the synchronised select is read, never the raw pin
	assign portIdle = ~spiSelected | nssSync;

	assign rxByte = {rxShift_reg[6:0], mosiSync};

	// receive side: bit count, byte phase, command and write handling
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			phase_reg <= PH_CMD;
			bitCnt_reg <= 3'h0;
			rxShift_reg <= 8'h00;
			addr_reg <= 7'h00;
			regWrStrobe <= 1'b0;
			regWrAddr <= 7'h00;
			regWrData <= 8'h00;
			regRdStrobe <= 1'b0;
			regRdAddr <= 7'h00;
			pushValid_reg <= 1'b0;
			pushData_reg <= 8'h00;
			pushDrop_reg <= 1'b0;
		end else if (portIdle) begin
			// select high clears all per-command state
			phase_reg <= PH_CMD;
			bitCnt_reg <= 3'h0;
			rxShift_reg <= 8'h00;
			addr_reg <= 7'h00;
			regWrStrobe <= 1'b0;
			regRdStrobe <= 1'b0;
			pushValid_reg <= 1'b0;
			pushDrop_reg <= 1'b0;
		end else begin
			// strobes are single-cycle pulses
			regWrStrobe <= 1'b0;
			regRdStrobe <= 1'b0;
			pushValid_reg <= 1'b0;
			pushDrop_reg <= 1'b0;
			if (sckRise) begin
				rxShift_reg <= rxByte;
				bitCnt_reg <= bitCnt_reg + 1'b1;
				if (bitCnt_reg == 3'h7) begin
					case (phase_reg)
						PH_CMD: begin
							// direction bit picks the phase for the whole stream
							if (rxByte[`CMD_DIR_BIT] == `CMD_DIR_READ) begin
								phase_reg <= PH_READ;
								regRdStrobe <= 1'b1;
								regRdAddr <= rxByte[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
							end else begin
								phase_reg <= PH_WRITE;
								addr_reg <= rxByte[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
							end
						end
						PH_READ: begin
							// each further byte with its LSB set is another read; a byte with LSB clear reads nothing
							if (rxByte[`CMD_DIR_BIT] == `CMD_DIR_READ) begin
								regRdStrobe <= 1'b1;
								regRdAddr <= rxByte[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
							end
						end
						PH_WRITE: begin
							// data bytes, any number, same select period
							if (addr_reg == `FIFO_REG_ADDR) begin
								// fifo address is a port, so the address stays
								pushValid_reg <= fifoInReady;
								pushData_reg <= rxByte;
								pushDrop_reg <= ~fifoInReady;
							end else begin
								regWrStrobe <= 1'b1;
								regWrAddr <= addr_reg;
								regWrData <= rxByte;
								addr_reg <= addr_reg + 1'b1;
							end
						end
						default: begin
							phase_reg <= PH_CMD;
						end
					endcase
				end
			end
		end
	end

	// transmit side: load read data, shift on falling edges
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			rdLoad_reg <= 1'b0;
			txNext_reg <= 8'h00;
			txShift_reg <= 8'h00;
			host_pin_2_out <= 1'b0;
			host_pin_2_oe <= 1'b0;
		end else if (portIdle) begin
			rdLoad_reg <= 1'b0;
			txNext_reg <= 8'h00;
			txShift_reg <= 8'h00;
			host_pin_2_out <= 1'b0;
			host_pin_2_oe <= 1'b0;
		end else begin
			host_pin_2_oe <= 1'b1;
			rdLoad_reg <= regRdStrobe;
			// read data fills the slot of the following byte
			// it lands two edges after the command byte, well ahead of the next falling edge
			if (rdLoad_reg) begin
				txNext_reg <= regRdData;
			end
			if (sckFall) begin
				if (bitCnt_reg == 3'h0) begin
					// falling edge after the last rising edge of a byte starts the next byte
					host_pin_2_out <= txNext_reg[7];
					txShift_reg <= {txNext_reg[6:0], 1'b0};
					txNext_reg <= 8'h00;
				end else begin
					host_pin_2_out <= txShift_reg[7];
					txShift_reg <= {txShift_reg[6:0], 1'b0};
				end
			end
		end
	end

	// sticky overflow; a new loss wins over a clear in the same cycle
	// clear is a level from the register side, no edge needed
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			fifoOverflow <= 1'b0;
		end else if (pushDrop_reg) begin
			fifoOverflow <= 1'b1;
		end else if (overflowClear) begin
			fifoOverflow <= 1'b0;
		end
	end

endmodule // host_if_select_spi_slave

`default_nettype wire

// [host_spi_check_sva.sv]
// checker for the host port: detection result, miso pin and register strobes
// assumes it is bound to host_if_select_spi_slave and sees only its ports
`include "host_spi_defines.vh"
`default_nettype none
module host_spi_check (
	input wire logic clock,
	input wire logic rst,
	input wire logic host_pin_1,
	input wire logic host_pin_3,
	input wire logic host_pin_2_out,
	input wire logic host_pin_2_oe,
	input wire logic powerDownResume,
	input wire logic [1:0] hostIfType,
	input wire logic spiSelected,
	input wire logic detectDone,
	input wire logic regWrStrobe,
	input wire logic [6:0] regWrAddr,
	input wire logic regRdStrobe,
	input wire logic fifoOutValid,
	input wire logic fifoInReady
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic [6:0] prevAddr_reg; // address of the last write in this frame
	logic havePrev_reg; // a write was seen since select went low
	// remember the last write; a raised select forgets it
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prevAddr_reg <= 7'h00;
			havePrev_reg <= 1'b0;
		end else if (host_pin_3) begin
			havePrev_reg <= 1'b0;
		end else if (regWrStrobe) begin
			prevAddr_reg <= regWrAddr;
			havePrev_reg <= 1'b1;
		end
	end
	idle_quiet_a: assert property (host_pin_3 [*4] |-> !host_pin_2_oe)
		else $error("miso driven while deselected");
	strap_gate_a: assert property (hostIfType != `IFTYPE_SPI |-> !host_pin_2_oe)
		else $error("miso driven in another mode");
	drive_sel_a: assert property ((spiSelected && !host_pin_3) [*4] |-> host_pin_2_oe)
		else $error("miso not driven while selected");
	sel_match_a: assert property (spiSelected |-> detectDone && hostIfType == `IFTYPE_SPI)
		else $error("spi flag disagrees with type");
	detect_time_a: assert property ($past(rst) && !rst |-> ##[1:10] detectDone)
		else $error("detection late after reset");
	type_hold_a: assert property (detectDone && !powerDownResume |=> detectDone && $stable(hostIfType))
		else $error("detected type changed");
	miso_fall_a: assert property ($changed(host_pin_2_out) && !host_pin_3 |-> !$past(host_pin_1, 2))
		else $error("miso moved outside the low phase");
	rd_space_a: assert property (regRdStrobe |=> !regRdStrobe [*8])
		else $error("read strobes too close");
	wr_step_a: assert property (regWrStrobe && havePrev_reg |->
		regWrAddr == (prevAddr_reg == `FIFO_REG_ADDR ? prevAddr_reg : prevAddr_reg + 7'h01))
		else $error("write address step wrong");
	fifo_push_a: assert property (regWrStrobe |-> regWrAddr != `FIFO_REG_ADDR)
		else $error("fifo byte sent to register port");
	fifo_full_a: assert property (!fifoInReady |-> fifoOutValid)
		else $error("fifo full with empty output");
endmodule // host_spi_check
bind host_if_select_spi_slave host_spi_check chk (
	.clock(clock),
	.rst(rst),
	.host_pin_1(host_pin_1),
	.host_pin_3(host_pin_3),
	.host_pin_2_out(host_pin_2_out),
	.host_pin_2_oe(host_pin_2_oe),
	.powerDownResume(powerDownResume),
	.hostIfType(hostIfType),
	.spiSelected(spiSelected),
	.detectDone(detectDone),
	.regWrStrobe(regWrStrobe),
	.regWrAddr(regWrAddr),
	.regRdStrobe(regRdStrobe),
	.fifoOutValid(fifoOutValid),
	.fifoInReady(fifoInReady)
);
`default_nettype wire

// [spi_host_model.sv]
// spi master standing in for the host controller, mode 0, msb first
// assumes the bench calls its tasks; serial clock period is 400 ns
`default_nettype none
module spi_host_model (
	output logic sck,
	output logic mosi,
	output logic nss,
	input wire logic misoOut,
	input wire logic misoOe
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int HALF = 200; // half serial clock period
	logic misoLast = 1'b0; // last level while driven
	wire miso;
	// a released line has no keeper: show the opposite of its last level
	always @(misoOut or misoOe) begin
		if (misoOe)
			misoLast = misoOut;
	end
	assign miso = misoOe ? misoOut : ~misoLast;
	initial begin
		sck = 1'b0;
		mosi = 1'b0;
		nss = 1'b1;
	end
	// open a frame off the bench clock phase
	task start();
		#13 nss = 1'b0;
		#HALF;
	endtask
	// shift nb bits; miso taken late in the high phase, the slave lags by its syncs
	task xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - nb; i--) begin
			mosi = tx[i];
			#HALF sck = 1'b1;
			#(HALF - 20) rx[i] = miso;
			#20 sck = 1'b0;
		end
	endtask
	// close the frame; select stays high long enough to reset the port
	task stop();
		#HALF nss = 1'b1;
		#HALF;
	endtask
endmodule // spi_host_model
`default_nettype wire

// [tb_top.sv]
// bench for the host port: strap detection, spi writes and reads, fifo fill and drain
// assumes the spi host model and the bound checker
`include "host_spi_defines.vh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic host_pin_0, host_pin_1, host_pin_3, host_pin_2_out, host_pin_2_oe;
	logic host_port_select_lo = 1'b0, host_port_select_hi = 1'b0, powerDownResume = 1'b0;
	logic fifoOutReady = 1'b0, overflowClear = 1'b0;
	logic spiSelected, detectDone, regWrStrobe, regRdStrobe, fifoOutValid, fifoInReady, fifoOverflow;
	logic [1:0] hostIfType;
	logic [6:0] regWrAddr, regRdAddr;
	logic [7:0] regWrData, regRdData, fifoOutData, r;
	logic [7:0] txq[$], rxq[$];
	logic [14:0] wrq[$]; // address and data of each write
	int n_mismatch = 0;
	int n_compared = 0;
	always #25 clock = ~clock;
	// register file stub: answers a pattern of the read address
	assign regRdData = {1'b1, regRdAddr} ^ 8'h5A;
	// collect register writes
	always @(posedge clock) if (regWrStrobe) wrq.push_back({regWrAddr, regWrData});
	spi_host_model host (.sck(host_pin_1), .mosi(host_pin_0), .nss(host_pin_3),
		.misoOut(host_pin_2_out), .misoOe(host_pin_2_oe));
	host_if_select_spi_slave dut (
		.clock(clock),
		.rst(rst),
		.host_pin_0(host_pin_0),
		.host_pin_1(host_pin_1),
		.host_pin_3(host_pin_3),
		.host_pin_2_out(host_pin_2_out),
		.host_pin_2_oe(host_pin_2_oe),
		.host_port_select_lo(host_port_select_lo),
		.host_port_select_hi(host_port_select_hi),
		.powerDownResume(powerDownResume),
		.hostIfType(hostIfType),
		.spiSelected(spiSelected),
		.detectDone(detectDone),
		.regWrStrobe(regWrStrobe),
		.regWrAddr(regWrAddr),
		.regWrData(regWrData),
		.regRdStrobe(regRdStrobe),
		.regRdAddr(regRdAddr),
		.regRdData(regRdData),
		.fifoOutValid(fifoOutValid),
		.fifoOutData(fifoOutData),
		.fifoOutReady(fifoOutReady),
		.fifoInReady(fifoInReady),
		.fifoOverflow(fifoOverflow),
		.overflowClear(overflowClear)
	);
	task finish_test();
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [14:0] got, input logic [14:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// bounded wait for detection of the wanted type
	task wait_type(input logic [1:0] t);
		int k;
		for (k = 0; k < 40 && !(detectDone === 1'b1 && hostIfType === t); k++)
			@(posedge clock);
		chk(15'(k < 40), 15'h1);
		if (k == 40)
			finish_test();
	endtask
	// send txq as one frame and gather miso bytes
	task frame();
		rxq = {};
		wrq = {};
		repeat (4) @(posedge clock);
		host.start();
		foreach (txq[i]) begin
			host.xfer(txq[i], 8, r);
			rxq.push_back(r);
		end
		host.stop();
		@(posedge clock) #2;
	endtask
	// each strap pattern, then latching and redetection on resume
	task t_detect();
		logic [1:0] straps[4] = '{2'h0, 2'h2, 2'h1, 2'h3};
		logic [1:0] types[4] = '{`IFTYPE_UART, `IFTYPE_SPI, `IFTYPE_I2C, `IFTYPE_I2CL};
		for (int i = 0; i < 4; i++) begin
			@(posedge clock) #2 {host_port_select_hi, host_port_select_lo} = straps[i];
			rst = 1'b1;
			@(posedge clock) #2 rst = 1'b0;
			wait_type(types[i]);
		end
		txq = '{8'h20, 8'h11};
		frame();
		chk(15'(wrq.size()), 15'h0);
		{host_port_select_hi, host_port_select_lo} = 2'h2;
		repeat (20) @(posedge clock);
		chk(15'(hostIfType), 15'(`IFTYPE_I2CL));
		#2 powerDownResume = 1'b1;
		@(posedge clock) #2 powerDownResume = 1'b0;
		wait_type(`IFTYPE_SPI);
	endtask
	// half a byte aborted, then a burst at the top of the address range
	task t_write();
		host.start();
		host.xfer(8'hFF, 4, r);
		host.stop();
		txq = '{8'hFC, 8'hC3, 8'h3C};
		frame();
		chk(15'(wrq.size()), 15'h2);
		chk(wrq[0], {7'h7E, 8'hC3});
		chk(wrq[1], {7'h7F, 8'h3C});
	endtask
	// two reads and the closing zero byte
	task t_read();
		txq = '{8'h43, 8'h7F, 8'h00};
		frame();
		chk(15'(wrq.size()), 15'h0);
		chk(15'(rxq[1]), 15'({1'b1, 7'h21} ^ 8'h5A));
		chk(15'(rxq[2]), 15'({1'b1, 7'h3F} ^ 8'h5A));
	endtask
	// overfill the fifo with its reader stalled, clear the flag, drain
	task t_fifo();
		int n;
		txq = '{8'h0A};
		for (int i = 1; i <= 33; i++)
			txq.push_back(8'(i));
		frame();
		// fifo bytes never reach the register port; the first waits at the output
		chk(15'(wrq.size()), 15'h0);
		chk(15'(fifoOutValid), 15'h1);
		chk(15'({fifoInReady, fifoOverflow}), 15'h1);
		overflowClear = 1'b1;
		@(posedge clock) #2 overflowClear = 1'b0;
		@(posedge clock) #2 chk(15'(fifoOverflow), 15'h0);
		fifoOutReady = 1'b1;
		n = 0;
		for (int k = 0; k < 200; k++) begin
			@(posedge clock);
			if (fifoOutValid === 1'b1) begin
				chk(15'(fifoOutData), 15'(n + 1));
				n++;
			end
		end
		chk(15'(n), 15'h20);
	endtask
	initial begin
		repeat (3) @(posedge clock);
		#2 rst = 1'b0;
		t_detect();
		t_write();
		t_read();
		t_fifo();
		finish_test();
	end
endmodule // tb_top
`default_nettype wire
